//--- include/dtsrc_pkg.sv
package dtsrc_pkg;
  localparam int NTHR = 2;
  localparam int VPN_W = 20;
  localparam int PPN_W = 20;
  localparam int LINE_W = 26;
  localparam int TLB_ENTRIES = 8;
  localparam int TLB_IDX_W = 3;
  localparam int DUTY_W = 3;
  localparam int A20_BIT = 20;
  localparam int EVT_N = 8;
  localparam int EVT_W = 3;
  localparam int NCNT = 2;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL0 = 12'h000;
  localparam logic [11:0] OFS_CTRL1 = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_RANGES = 12'h00c;
  localparam logic [11:0] OFS_PCNT0 = 12'h010;
  localparam logic [11:0] OFS_PCTL0 = 12'h018;
  localparam logic [11:0] OFS_STEP = 12'h004;
  // per-thread control word
  localparam int CTL_CD_BIT = 0;
  localparam int CTL_THR_EN_BIT = 1;
  localparam int CTL_DUTY_LSB = 2;
  localparam int CTL_MASKA_BIT = 8;
  localparam int CTL_MASKB_BIT = 9;
  localparam logic [31:0] CTRL_WMASK = 32'h0000031f;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  // status word
  localparam int SB_CD = 0;
  localparam int SB_STALL_LSB = 1;
  localparam int SB_BUSY = 3;
  localparam int SB_STOPGNT = 4;
  localparam int SB_THERM = 5;
  localparam int SB_HALT = 6;
  localparam int SB_DUTY_LSB = 8;
  localparam int SB_MODON = 11;
  // counter control word
  localparam int PC_EVT_LSB = 0;
  localparam int PC_T0_BIT = 4;
  localparam int PC_T1_BIT = 5;
  localparam int PC_IRQ_BIT = 6;
  localparam int PC_IRQTHR_BIT = 7;
  localparam int PC_PRECISE_BIT = 8;
  localparam logic [31:0] PCTL_WMASK = 32'h000001f7;
  localparam logic [31:0] RANGES_RST = 32'h00000000;
  // duty used on a thermal trip, last slot on out of eight (slots 0 to duty run)
  localparam logic [DUTY_W-1:0] THERM_DUTY = 3'h3;
  localparam logic [DUTY_W-1:0] FULL_DUTY = 3'h7;

  typedef enum logic [1:0] {OP_NONE, OP_WB_INV, OP_INV_ONLY, OP_LINE_FLUSH} dtsrc_op_type;
  typedef enum logic [1:0] {CC_NONE, CC_WRITEBACK_ALL, CC_INVALIDATE_ALL, CC_FLUSH_LINE}
    dtsrc_ccmd_type;
  typedef enum {S_IDLE, S_WB_ALL, S_INV_ALL, S_FLUSH, S_SPECIAL, S_DONE} dtsrc_state_type;

  typedef struct packed {
    logic valid;
    dtsrc_op_type kind;
    logic [LINE_W-1:0] line;
  } dtsrc_op_req_type;

  typedef struct packed {
    logic valid;
    logic tid;
    logic glob;
    logic [VPN_W-1:0] vpn;
    logic [PPN_W-1:0] ppn;
  } dtsrc_tlb_fill_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } dtsrc_bus_req_type;
endpackage

//--- hdl/dtsrc_tlb.sv
`timescale 1ns/1ps
`default_nettype none
module dtsrc_tlb
  import dtsrc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // fill
  input wire dtsrc_tlb_fill_type fill,
  // lookup
  input wire logic lookupTid,
  input wire logic [VPN_W-1:0] lookupVpn,
  output logic lookupHit,
  output logic [PPN_W-1:0] lookupPpn,
  // invalidation, one lane per thread
  input wire logic [NTHR-1:0] invAll,
  input wire logic [NTHR-1:0] invKeepGlob,
  input wire logic [NTHR-1:0] invPage,
  input wire logic [NTHR-1:0][VPN_W-1:0] invVpn
);
  logic [TLB_ENTRIES-1:0] valid_q;
  logic [TLB_ENTRIES-1:0] valid_d;
  logic [TLB_ENTRIES-1:0] hitVec;
  logic [TLB_ENTRIES-1:0] dropVec;
  logic [TLB_ENTRIES-1:0] tid_q;
  logic [TLB_ENTRIES-1:0] glob_q;
  logic [VPN_W-1:0] vpn_q [TLB_ENTRIES];
  logic [PPN_W-1:0] ppn_q [TLB_ENTRIES];
  logic [TLB_IDX_W-1:0] repl_q;
  logic [PPN_W-1:0] selPpn;

  //////////////////////////////////////////////////////////////////////////////
  genvar e;
  generate
    for (e = 0; e < TLB_ENTRIES; e++)
    begin : g_ent
      // thread tag on match
      // global entries still match only their own thread
      assign hitVec[e] = valid_q[e] & (tid_q[e] == lookupTid) & (vpn_q[e] == lookupVpn);
      assign dropVec[e] = (invAll[tid_q[e]] & ~(invKeepGlob[tid_q[e]] & glob_q[e]))
        | (invPage[tid_q[e]] & (vpn_q[e] == invVpn[tid_q[e]]));
      assign valid_d[e] = (fill.valid && repl_q == TLB_IDX_W'(e)) ? 1'b1
        : (valid_q[e] & ~dropVec[e]);
    end
  endgenerate

  always_comb
  begin
    selPpn = '0;
    for (int i = 0; i < TLB_ENTRIES; i++)
    begin
      if (hitVec[i])
        selPpn = ppn_q[i];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      valid_q <= '0;
      repl_q <= '0;
      lookupHit <= 1'b0;
      lookupPpn <= '0;
    end
    else
    begin
      valid_q <= valid_d;
      lookupHit <= |hitVec;
      lookupPpn <= selPpn;
      if (fill.valid)
        repl_q <= repl_q + TLB_IDX_W'(1);
    end
  end

  // entry payload needs no reset, valid bits guard it
  always_ff @(posedge sys_clk)
  begin
    if (fill.valid)
    begin
      vpn_q[repl_q] <= fill.vpn;
      ppn_q[repl_q] <= fill.ppn;
      tid_q[repl_q] <= fill.tid;
      glob_q[repl_q] <= fill.glob;
    end
  end
endmodule
`default_nettype wire

//--- hdl/dtsrc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dtsrc_ctrl
  import dtsrc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // thread cache requests and stall
  input wire dtsrc_op_req_type [NTHR-1:0] opReq,
  output logic [NTHR-1:0] opStall,
  output logic opDone,
  // cache array and bus special cycle
  output dtsrc_ccmd_type cacheCmd,
  output logic [LINE_W-1:0] cacheLine,
  input wire logic cacheDone,
  output logic busSpecialReq,
  output dtsrc_op_type busSpecialKind,
  input wire logic busSpecialAck,
  // translation buffers
  input wire dtsrc_tlb_fill_type dtlbFill,
  input wire logic dtlbTid,
  input wire logic [VPN_W-1:0] dtlbVpn,
  output logic dtlbHit,
  output logic [PPN_W-1:0] dtlbPpn,
  input wire dtsrc_tlb_fill_type [NTHR-1:0] itlbFill,
  input wire logic [NTHR-1:0][VPN_W-1:0] itlbVpn,
  output logic [NTHR-1:0] itlbHit,
  output logic [NTHR-1:0][PPN_W-1:0] itlbPpn,
  input wire logic [NTHR-1:0] pageTableBaseWr,
  input wire logic [NTHR-1:0] pagingFeatureWr,
  input wire logic [NTHR-1:0] singlePageInv,
  input wire logic [NTHR-1:0][VPN_W-1:0] singlePageVpn,
  // thermal and power pins
  input wire logic catTrip,
  input wire logic thermTrip,
  input wire logic stop_clock_in_n,
  output logic coreClkEn,
  output logic [NTHR-1:0] threadRun,
  output logic [NTHR-1:0] irqAccept,
  output logic snoopRespEn,
  output logic cacheDisable,
  // local interrupt pins
  input wire logic local_irq_in_a,
  input wire logic local_irq_in_b,
  output logic [NTHR-1:0] lintA,
  output logic [NTHR-1:0] lintB,
  // external bus address path
  input wire logic addr_bit20_mask_n,
  input wire dtsrc_bus_req_type busReqIn,
  output dtsrc_bus_req_type busReqOut,
  // shared resources
  output logic [31:0] memTypeRanges,
  input wire logic [NTHR-1:0][EVT_N-1:0] perfEvt,
  output logic [NTHR-1:0] perfIrq,
  output logic [NTHR-1:0] perfPrecise,
  // code modification detection
  input wire logic [NTHR-1:0] fetchValid,
  input wire logic [NTHR-1:0][LINE_W-1:0] fetchLine,
  input wire logic [NTHR-1:0] dataWrValid,
  input wire logic [NTHR-1:0][LINE_W-1:0] dataWrLine,
  input wire logic snoopWrValid,
  input wire logic [LINE_W-1:0] snoopWrLine,
  output logic [NTHR-1:0] smcFlush
);
  function automatic logic isReg(input logic [11:0] a, input logic [11:0] ofs);
    isReg = (a == ofs);
  endfunction

  function automatic logic [NTHR-1:0] stallFor(input dtsrc_op_req_type r, input logic tid);
    stallFor = '0;
    if (r.valid)
      stallFor = (r.kind == OP_LINE_FLUSH) ? (tid ? 2'h2 : 2'h1) : 2'h3;
  endfunction

  function automatic logic lintDeliver(input logic pin, input logic mask, input logic block);
    lintDeliver = pin & ~mask & ~block;
  endfunction

  logic [NTHR-1:0][31:0] ctrl_q;
  logic [NCNT-1:0][31:0] pcnt_q;
  logic [NCNT-1:0][31:0] pctl_q;
  logic [31:0] ranges_q;
  logic [31:0] status;
  logic [31:0] rdMux;
  logic mapped;
  logic wrEn;
  dtsrc_state_type state_q;
  dtsrc_state_type state_d;
  dtsrc_op_req_type [NTHR-1:0] pend_q;
  dtsrc_op_req_type cur_q;
  dtsrc_op_req_type nextReq;
  logic nextTid;
  logic anyPend;
  logic take;
  logic [NTHR-1:0] stall_q;
  logic [NTHR-1:0] stall_d;
  dtsrc_state_type startState;
  logic halt_q;
  logic stopGrant;
  logic [2:0] slot_q;
  logic [DUTY_W-1:0] swDuty;
  logic [DUTY_W-1:0] effDuty;
  logic swModOn;
  logic modOn;
  logic [NTHR-1:0] thrEn;
  logic [NTHR-1:0][DUTY_W-1:0] thrDuty;
  logic [NCNT-1:0][NTHR-1:0] ovfIrq;
  logic [NCNT-1:0][NTHR-1:0] precSel;
  logic [NTHR-1:0] smcHit;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states
  assign wrEn = psel & penable & pwrite;
  assign mapped = isReg(paddr, OFS_CTRL0) | isReg(paddr, OFS_CTRL1)
    | isReg(paddr, OFS_STATUS) | isReg(paddr, OFS_RANGES)
    | isReg(paddr, OFS_PCNT0) | isReg(paddr, OFS_PCNT0 + OFS_STEP)
    | isReg(paddr, OFS_PCTL0) | isReg(paddr, OFS_PCTL0 + OFS_STEP);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign rdMux = isReg(paddr, OFS_CTRL0) ? ctrl_q[0]
    : isReg(paddr, OFS_CTRL1) ? ctrl_q[1]
    : isReg(paddr, OFS_STATUS) ? status
    : isReg(paddr, OFS_RANGES) ? ranges_q
    : isReg(paddr, OFS_PCNT0) ? pcnt_q[0]
    : isReg(paddr, OFS_PCNT0 + OFS_STEP) ? pcnt_q[1]
    : isReg(paddr, OFS_PCTL0) ? pctl_q[0]
    : isReg(paddr, OFS_PCTL0 + OFS_STEP) ? pctl_q[1]
    : 32'h00000000;
  assign status = {20'h00000, swModOn | thermTrip, effDuty, 1'b0, halt_q, thermTrip,
    stopGrant, state_q != S_IDLE, stall_q, cacheDisable};

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      prdata <= '0;
    else if (psel && !penable)
      prdata <= rdMux;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= {NTHR{CTRL_RST}};
      ranges_q <= RANGES_RST;
    end
    else if (wrEn)
    begin
      if (isReg(paddr, OFS_CTRL0))
        ctrl_q[0] <= pwdata & CTRL_WMASK;
      if (isReg(paddr, OFS_CTRL1))
        ctrl_q[1] <= pwdata & CTRL_WMASK;
      if (isReg(paddr, OFS_RANGES))
        ranges_q <= pwdata;
    end
  end
  assign memTypeRanges = ranges_q;

  //////////////////////////////////////////////////////////////////////////////
  // fixed priority, thread 0 first
  assign anyPend = pend_q[0].valid | pend_q[1].valid;
  assign nextTid = ~pend_q[0].valid;
  assign nextReq = pend_q[nextTid];
  assign startState = (nextReq.kind == OP_WB_INV) ? S_WB_ALL
    : (nextReq.kind == OP_INV_ONLY) ? S_INV_ALL : S_FLUSH;

  always_comb
  begin
    state_d = state_q;
    stall_d = stall_q;
    take = 1'b0;
    case (state_q)
      S_IDLE:
        if (anyPend)
        begin
          take = 1'b1;
          stall_d = stallFor(nextReq, nextTid);
          state_d = startState;
        end
      S_WB_ALL:
        if (cacheDone)
          state_d = S_INV_ALL;
      S_INV_ALL:
        if (cacheDone)
          state_d = S_SPECIAL;
      S_FLUSH:
        if (cacheDone)
          state_d = S_SPECIAL;
      S_SPECIAL:
        if (busSpecialAck)
          state_d = S_DONE;
      // with nothing pending, stall drops one cycle after done
      S_DONE:
        if (anyPend)
        begin
          take = 1'b1;
          stall_d = stall_q | stallFor(nextReq, nextTid);
          state_d = startState;
        end
        else
        begin
          stall_d = '0;
          state_d = S_IDLE;
        end
      default:
        state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= S_IDLE;
      stall_q <= '0;
      cur_q <= '0;
      pend_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      stall_q <= stall_d;
      if (take)
        cur_q <= nextReq;
      for (int i = 0; i < NTHR; i++)
      begin
        // a new request wins over the hand-off clear
        if (opReq[i].valid && opReq[i].kind != OP_NONE)
          pend_q[i] <= opReq[i];
        else if (take && nextTid == 1'(i))
          pend_q[i] <= '0;
      end
    end
  end

  // one shared cache, no thread field on commands
  assign cacheCmd = (state_q == S_WB_ALL) ? CC_WRITEBACK_ALL
    : (state_q == S_INV_ALL) ? CC_INVALIDATE_ALL
    : (state_q == S_FLUSH) ? CC_FLUSH_LINE : CC_NONE;
  assign cacheLine = cur_q.line;
  assign busSpecialReq = state_q == S_SPECIAL;
  assign busSpecialKind = cur_q.kind;
  assign opDone = state_q == S_DONE;
  // pending ops stall at once, not a cycle late
  assign opStall = stall_q | stallFor(pend_q[0], 1'b0) | stallFor(pend_q[1], 1'b1);

  //////////////////////////////////////////////////////////////////////////////
  // shared data buffer, tid from the filler
  dtsrc_tlb u_dtlb (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .fill(dtlbFill),
    .lookupTid(dtlbTid),
    .lookupVpn(dtlbVpn),
    .lookupHit(dtlbHit),
    .lookupPpn(dtlbPpn),
    .invAll(pageTableBaseWr | pagingFeatureWr),
    .invKeepGlob(pageTableBaseWr & ~pagingFeatureWr),
    .invPage(singlePageInv),
    .invVpn(singlePageVpn)
  );

  genvar t;
  generate
    for (t = 0; t < NTHR; t++)
    begin : g_thr
      dtsrc_tlb_fill_type iFill;
      logic [NTHR-1:0] laneSel;
      assign laneSel = NTHR'(1) << t;
      // own-thread tag forced on instruction entries
      assign iFill = '{valid: itlbFill[t].valid, tid: 1'(t), glob: itlbFill[t].glob,
        vpn: itlbFill[t].vpn, ppn: itlbFill[t].ppn};
      dtsrc_tlb u_itlb (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .fill(iFill),
        .lookupTid(1'(t)),
        .lookupVpn(itlbVpn[t]),
        .lookupHit(itlbHit[t]),
        .lookupPpn(itlbPpn[t]),
        .invAll((pageTableBaseWr | pagingFeatureWr) & laneSel),
        .invKeepGlob(pageTableBaseWr & ~pagingFeatureWr & laneSel),
        .invPage(singlePageInv & laneSel),
        .invVpn(singlePageVpn)
      );
      assign thrEn[t] = ctrl_q[t][CTL_THR_EN_BIT];
      assign thrDuty[t] = ctrl_q[t][CTL_DUTY_LSB +: DUTY_W];
      // own, sibling and foreign writes all compared
      assign smcHit[t] = fetchValid[t] & (
        (dataWrValid[0] & (dataWrLine[0] == fetchLine[t]))
        | (dataWrValid[1] & (dataWrLine[1] == fetchLine[t]))
        | (snoopWrValid & (snoopWrLine == fetchLine[t])));
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // highest enabled duty wins
  assign swModOn = |thrEn;
  assign swDuty = (thrEn == 2'h3) ? ((thrDuty[0] > thrDuty[1]) ? thrDuty[0] : thrDuty[1])
    : thrEn[0] ? thrDuty[0] : thrEn[1] ? thrDuty[1] : FULL_DUTY;
  assign modOn = thermTrip | swModOn;
  assign effDuty = thermTrip ? THERM_DUTY : swDuty;
  assign stopGrant = ~stop_clock_in_n;
  assign snoopRespEn = ~halt_q;
  // no execution, no interrupts in stop-grant
  assign irqAccept = {NTHR{~stopGrant & ~halt_q}};
  // halt is sticky until reset; sensor may chatter
  assign threadRun = ~({NTHR{stopGrant | halt_q}} | opStall);

  //////////////////////////////////////////////////////////////////////////////
  // one counter set per core
  generate
    for (t = 0; t < NCNT; t++)
    begin : g_cnt
      logic [EVT_W-1:0] sel;
      logic [1:0] inc;
      logic [32:0] sum;
      assign sel = pctl_q[t][PC_EVT_LSB +: EVT_W];
      assign inc = {1'b0, pctl_q[t][PC_T0_BIT] & perfEvt[0][sel]}
        + {1'b0, pctl_q[t][PC_T1_BIT] & perfEvt[1][sel]};
      assign sum = {1'b0, pcnt_q[t]} + {31'h00000000, inc};
      // overflow interrupt routed to chosen thread
      assign ovfIrq[t] = (sum[32] & pctl_q[t][PC_IRQ_BIT])
        ? (pctl_q[t][PC_IRQTHR_BIT] ? 2'h2 : 2'h1) : 2'h0;
      assign precSel[t] = pctl_q[t][PC_PRECISE_BIT]
        ? {pctl_q[t][PC_T1_BIT], pctl_q[t][PC_T0_BIT]} : 2'h0;
      always_ff @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          pcnt_q[t] <= '0;
          pctl_q[t] <= '0;
        end
        else
        begin
          // software write beats the count in the same cycle
          if (wrEn && isReg(paddr, OFS_PCNT0 + 12'(t * 4)))
            pcnt_q[t] <= pwdata;
          else
            pcnt_q[t] <= sum[31:0];
          if (wrEn && isReg(paddr, OFS_PCTL0 + 12'(t * 4)))
            pctl_q[t] <= pwdata & PCTL_WMASK;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      halt_q <= 1'b0;
      slot_q <= '0;
      coreClkEn <= 1'b1;
      cacheDisable <= 1'b0;
      lintA <= '0;
      lintB <= '0;
      busReqOut <= '0;
      perfIrq <= '0;
      perfPrecise <= '0;
      smcFlush <= '0;
    end
    else
    begin
      if (catTrip)
        halt_q <= 1'b1;
      slot_q <= slot_q + 3'h1;
      // modulation gates the shared core clock
      coreClkEn <= ~halt_q & ~catTrip & (~modOn | (slot_q <= effDuty));
      cacheDisable <= ctrl_q[0][CTL_CD_BIT] | ctrl_q[1][CTL_CD_BIT];
      for (int i = 0; i < NTHR; i++)
      begin
        // shared pin fanned out, masked per thread
        lintA[i] <= lintDeliver(local_irq_in_a, ctrl_q[i][CTL_MASKA_BIT], stopGrant);
        lintB[i] <= lintDeliver(local_irq_in_b, ctrl_q[i][CTL_MASKB_BIT], stopGrant);
      end
      busReqOut <= busReqIn;
      busReqOut.addr[A20_BIT] <= busReqIn.addr[A20_BIT] & addr_bit20_mask_n;
      perfIrq <= ovfIrq[0] | ovfIrq[1];
      perfPrecise <= precSel[0] | precSel[1];
      smcFlush <= smcHit;
    end
  end
endmodule
`default_nettype wire

//--- bench/dtsrc_props.sv
`timescale 1ns/1ps
`default_nettype none
module dtsrc_props
  import dtsrc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // cache operations
  input wire dtsrc_op_req_type [NTHR-1:0] opReq,
  input wire logic [NTHR-1:0] opStall,
  input wire logic opDone,
  input wire dtsrc_ccmd_type cacheCmd,
  input wire logic cacheDone,
  input wire logic busSpecialReq,
  input wire logic busSpecialAck,
  // power and pins
  input wire logic catTrip,
  input wire logic coreClkEn,
  input wire logic stop_clock_in_n,
  input wire logic [NTHR-1:0] threadRun,
  input wire logic [NTHR-1:0] irqAccept,
  input wire logic snoopRespEn,
  input wire logic addr_bit20_mask_n,
  input wire dtsrc_bus_req_type busReqIn,
  input wire dtsrc_bus_req_type busReqOut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  AST_WB_STALL: assert property (
    opReq[0].valid && opReq[0].kind == OP_WB_INV |=> opStall == 2'b11)
    else $error("wb-inv did not stall both");
  AST_CMD_HOLD: assert property (cacheCmd != CC_NONE && !cacheDone |=> $stable(cacheCmd))
    else $error("cache command dropped early");
  AST_SPC_HOLD: assert property (busSpecialReq && !busSpecialAck |=> busSpecialReq)
    else $error("special cycle dropped early");
  AST_DONE_ACK: assert property (opDone |-> $past(busSpecialAck))
    else $error("done without bus cycle");
  AST_RESUME: assert property ($fell(opStall[1]) |-> $past(opDone))
    else $error("stall fell without done");
  AST_STOPGNT: assert property (
    !stop_clock_in_n |-> !threadRun && !irqAccept && snoopRespEn)
    else $error("stop-grant not honoured");
  AST_ADDR20: assert property (busReqIn.valid && !addr_bit20_mask_n |=>
    busReqOut.addr == ($past(busReqIn.addr) & ~(32'h1 << A20_BIT)))
    else $error("address bit 20 not masked");
  AST_HALT: assert property (catTrip |=> !coreClkEn)
    else $error("core not halted");
  cover property (opReq[1].valid && opReq[0].valid);
  cover property (opDone);
  cover property (!stop_clock_in_n);
endmodule
bind dtsrc_ctrl dtsrc_props i_dtsrc_props (.*);
`default_nettype wire

//--- bench/dtsrc_cache_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtsrc_cache_model
  import dtsrc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // answer delay in cycles
  input wire logic [3:0] lat,
  // cache array and bus
  input wire dtsrc_ccmd_type cacheCmd,
  output logic cacheDone,
  input wire logic busSpecialReq,
  output logic busSpecialAck
);
  logic [3:0] cnt_q;
  wire logic busyC = cacheCmd != CC_NONE && !cacheDone;
  wire logic busyS = busSpecialReq && !busSpecialAck;
  // one pulse each; a held answer would finish two steps
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 4'h0;
      cacheDone <= 1'b0;
      busSpecialAck <= 1'b0;
    end
    else
    begin
      cacheDone <= busyC && cnt_q >= lat;
      busSpecialAck <= busyS && cnt_q >= lat;
      cnt_q <= ((busyC || busyS) && cnt_q < lat) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_dtsrc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dtsrc_ctrl
  import dtsrc_pkg::*;
;
  typedef struct {logic t; dtsrc_op_type k; logic [1:0] st; dtsrc_ccmd_type c;} dtsrc_row_type;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, memTypeRanges;
  dtsrc_op_req_type [NTHR-1:0] opReq = '0;
  logic [NTHR-1:0] opStall, itlbHit, threadRun, irqAccept, lintA, lintB, perfIrq, perfPrecise;
  logic [NTHR-1:0] smcFlush, fetchValid = 0, dataWrValid = 0, singlePageInv = 0;
  logic [NTHR-1:0] pageTableBaseWr = 0, pagingFeatureWr = 0;
  logic opDone, cacheDone, busSpecialReq, busSpecialAck, dtlbHit, dtlbTid = 0;
  dtsrc_ccmd_type cacheCmd;
  dtsrc_op_type busSpecialKind;
  logic [LINE_W-1:0] cacheLine, snoopWrLine = 0;
  dtsrc_tlb_fill_type dtlbFill = '0;
  dtsrc_tlb_fill_type [NTHR-1:0] itlbFill = '0;
  logic [VPN_W-1:0] dtlbVpn = 0;
  logic [PPN_W-1:0] dtlbPpn;
  logic [NTHR-1:0][VPN_W-1:0] itlbVpn = '0, singlePageVpn = '0;
  logic [NTHR-1:0][PPN_W-1:0] itlbPpn;
  logic catTrip = 0, thermTrip = 0, stop_clock_in_n = 1, coreClkEn, snoopRespEn, cacheDisable;
  logic local_irq_in_a = 0, local_irq_in_b = 0, addr_bit20_mask_n = 1, snoopWrValid = 0;
  dtsrc_bus_req_type busReqIn = '0, busReqOut;
  logic [NTHR-1:0][EVT_N-1:0] perfEvt = '0;
  logic [NTHR-1:0][LINE_W-1:0] fetchLine = '0, dataWrLine = '0;
  logic [3:0] lat = 0;
  int num_errors = 0, n_tests = 0;
  dtsrc_row_type rows[4] = '{'{0, OP_WB_INV, 2'b11, CC_WRITEBACK_ALL},
    '{1, OP_INV_ONLY, 2'b11, CC_INVALIDATE_ALL}, '{0, OP_LINE_FLUSH, 2'b01, CC_FLUSH_LINE},
    '{1, OP_LINE_FLUSH, 2'b10, CC_FLUSH_LINE}};

  dtsrc_ctrl i_dtsrc_ctrl (.*);
  dtsrc_cache_model i_dtsrc_cache_model (.*);
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task cy(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task op(input logic [1:0] m, input dtsrc_op_type k0, input dtsrc_op_type k1);
    @(posedge sys_clk);
    opReq[0] <= '{m[0], k0, 26'h15};
    opReq[1] <= '{m[1], k1, 26'h2a};
    @(posedge sys_clk);
    opReq <= '0;
    #1;
  endtask
  task wait_done;
    int k;
    k = 0;
    do
    begin
      cy(1);
      k++;
    end
    while (opDone !== 1'b1 && k < 200);
    chk("opDone", 1, opDone);
  endtask
  task look(input logic t);
    @(posedge sys_clk);
    dtlbTid <= t;
    dtlbVpn <= 20'h1;
    cy(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // deadline well past the longest chain of bounded waits
  initial
  begin
    #100000;
    num_errors++;
    close_out;
  end
  initial
  begin
    cy(7);
    chk("rst stall", 0, opStall);
    chk("rst run", 3, threadRun);
    // release on the eighth edge, by nba like every other input
    @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge sys_clk);
      lat <= 4'(i);
      op(2'b01 << rows[i].t, rows[i].k, rows[i].k);
      chk("stall", rows[i].st, opStall);
      cy(1);
      chk("cmd", rows[i].c, cacheCmd);
      wait_done;
      chk("kind", rows[i].k, busSpecialKind);
      chk("line", rows[i].t ? 26'h2a : 26'h15, cacheLine);
      cy(1);
      chk("resume", 0, opStall);
    end
    op(2'b11, OP_WB_INV, OP_INV_ONLY);
    wait_done;
    cy(1);
    chk("held", 3, opStall);
    wait_done;
    cy(1);
    chk("both", 0, opStall);
    for (int t = 0; t < 2; t++)
    begin
      apb(1'b1, t ? OFS_CTRL1 : OFS_CTRL0, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status cd", 1, rd[SB_CD]);
      chk("cd on", 1, cacheDisable);
      apb(1'b1, t ? OFS_CTRL1 : OFS_CTRL0, 32'h0);
      cy(2);
      chk("cd off", 0, cacheDisable);
    end
    // duty 5 on thread 0, duty 2 on thread 1
    apb(1'b1, OFS_CTRL0, 32'h16);
    apb(1'b1, OFS_CTRL1, 32'h0a);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("duty max", 5, rd[SB_DUTY_LSB +: DUTY_W]);
    chk("mod on", 1, rd[SB_MODON]);
    apb(1'b1, OFS_CTRL1, 32'h16);
    @(posedge sys_clk);
    thermTrip <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("duty trip", THERM_DUTY, rd[SB_DUTY_LSB +: DUTY_W]);
    apb(1'b1, OFS_RANGES, 32'h5a);
    apb(1'b1, 12'hffc, 32'hff);
    chk("slverr", 1, er);
    chk("ranges", 32'h5a, memTypeRanges);
    // counter 0 counts thread 1 event 0, irq and precise to thread 1
    apb(1'b1, OFS_PCTL0, 32'h1e0);
    apb(1'b1, OFS_PCNT0, 32'hffffffff);
    @(posedge sys_clk);
    perfEvt[1] <= 8'h01;
    cy(1);
    chk("perf irq", 2, perfIrq);
    chk("perf precise", 2, perfPrecise);
    @(posedge sys_clk);
    fetchValid[1] <= 1'b1;
    fetchLine[1] <= 26'h33;
    dataWrValid[0] <= 1'b1;
    dataWrLine[0] <= 26'h33;
    cy(1);
    chk("smc", 2, smcFlush);
    @(posedge sys_clk);
    itlbFill[1] <= '{1'b1, 1'b0, 1'b0, 20'h7, 20'hcc};
    itlbVpn[1] <= 20'h7;
    @(posedge sys_clk);
    itlbFill <= '0;
    cy(1);
    chk("itlb tag", 32'hcc, itlbPpn[1]);
    chk("itlb own", 0, itlbHit[0]);
    @(posedge sys_clk);
    local_irq_in_a <= 1'b1;
    local_irq_in_b <= 1'b1;
    cy(2);
    chk("lint both", 3, lintA);
    chk("lint b", 3, lintB);
    apb(1'b1, OFS_CTRL0, 32'h1 << CTL_MASKA_BIT);
    cy(2);
    chk("lint mask", 2, lintA);
    @(posedge sys_clk);
    stop_clock_in_n <= 1'b0;
    cy(2);
    chk("irq", 0, irqAccept);
    chk("lint stop", 0, lintA);
    chk("snoop", 1, snoopRespEn);
    @(posedge sys_clk);
    stop_clock_in_n <= 1'b1;
    busReqIn <= '{1'b1, 1'b0, 32'hffffffff};
    addr_bit20_mask_n <= 1'b0;
    cy(1);
    chk("a20 on", 32'hffffffff & ~(32'h1 << A20_BIT), busReqOut.addr);
    @(posedge sys_clk);
    addr_bit20_mask_n <= 1'b1;
    cy(2);
    chk("a20 off", 32'hffffffff, busReqOut.addr);
    @(posedge sys_clk);
    dtlbFill <= '{1'b1, 1'b0, 1'b1, 20'h1, 20'haa};
    @(posedge sys_clk);
    dtlbFill <= '{1'b1, 1'b1, 1'b0, 20'h1, 20'hbb};
    @(posedge sys_clk);
    dtlbFill <= '0;
    look(1'b1);
    chk("tlb ppn", 32'hbb, dtlbPpn);
    @(posedge sys_clk);
    singlePageInv[0] <= 1'b1;
    singlePageVpn[0] <= 20'h1;
    @(posedge sys_clk);
    singlePageInv <= '0;
    look(1'b0);
    chk("tlb own", 0, dtlbHit);
    look(1'b1);
    chk("tlb other", 1, dtlbHit);
    @(posedge sys_clk);
    catTrip <= 1'b1;
    cy(4);
    chk("halt", 0, coreClkEn);
    close_out;
  end
endmodule
`default_nettype wire
